// File: hdl/vss_pkg.sv
package vss_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int CLK_FREQ_KHZ = 1000000 / CLK_PERIOD_NS;
  localparam int REF_W = 13;
  localparam int CODE_W = 8;
  localparam int CUR_W = 12;
  localparam int TMR_W = 24;
  localparam int ACC_W = 23;
  // reference counts in 0.25 mV units
  localparam logic [REF_W-1:0] CODE_LSB_UNITS = 13'h0019;
  localparam logic [REF_W-1:0] BOOT_UNITS = 13'h10E4;
  localparam logic [REF_W-1:0] UV_ARM_UNITS = 13'h07D0;
  localparam logic [REF_W-1:0] OV_FIXED_UNITS = 13'h1360;
  localparam logic [REF_W-1:0] OV_MARGIN_UNITS = 13'h0320;
  localparam logic [CODE_W-1:0] OFF_CODE_LO = 8'h00;
  localparam logic [CODE_W-1:0] OFF_CODE_HI = 8'hFF;
  localparam int STEP_CLK_FREQ_KHZ = 1000;
  localparam int STEP_DIV = CLK_FREQ_KHZ / STEP_CLK_FREQ_KHZ;
  localparam logic [5:0] STEP_LAST = 6'(STEP_DIV - 1);
  localparam logic [5:0] STEP_HALF = 6'(STEP_DIV / 2);
  localparam logic [4:0] MASK_HOLDOFF_STEPS = 5'h10;
  localparam int INIT_DELAY_US = 2000;
  localparam int INIT_DELAY_CYC = (INIT_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BOOT_HOLD_US = 200;
  localparam int BOOT_HOLD_CYC = BOOT_HOLD_US * 1000 / CLK_PERIOD_NS;
  localparam logic [14:0] SS_NS_PER_KOHM = 15'h4858;
  localparam logic [ACC_W-1:0] SS_ACC_INC = ACC_W'(CLK_PERIOD_NS * 4324);
  localparam logic [7:0] RAMP_KOHM_RST = 8'h1B;
  localparam logic [11:0] DIV3_MUL = 12'h556;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_RAMP = 8'h04;
  localparam logic [7:0] ADDR_REF = 8'h08;
  localparam logic [7:0] ADDR_CURRENT = 8'h0C;
  localparam int STAT_PGOOD_BIT = 4;
  localparam int STAT_FOV_BIT = 5;
  localparam int STAT_FOC_BIT = 6;
  localparam int STAT_FUV_BIT = 7;
  localparam int STAT_FOFF_BIT = 8;
  localparam int STAT_DYNAMIC_CODE_CHANGE_BIT = 9;
  localparam int STAT_MASK_BIT = 10;
  localparam int STAT_PHASE_LSB = 12;
  localparam int REF_TARGET_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef logic [3:0][CUR_W-1:0] vss_cur_t;
  typedef logic [3:0][CUR_W:0] vss_trim_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_DELAY, ST_RAMP_BOOT, ST_HOLD, ST_RAMP_FINAL, ST_RUN, ST_FAULT
  } vss_state_e;

  typedef struct packed {
    vss_state_e state;
    logic [REF_W-1:0] ref_lvl;
    logic [REF_W-1:0] target;
    logic [CODE_W-1:0] code;
    logic [CODE_W-1:0] cand;
    logic cand_pend;
    logic dynamic_code_change_go;
    logic dynamic_code_change_act;
    logic step_par;
    logic [5:0] step_div;
    logic [4:0] holdoff;
    logic [TMR_W-1:0] tmr;
    logic [ACC_W-1:0] ss_acc;
    logic uv_arm;
    logic first_pulse;
    logic [3:0] phase_mask;
    logic f_ov;
    logic f_oc;
    logic f_uv;
    logic f_off;
    vss_trim_t trim;
    logic [CUR_W-1:0] avg;
    logic [3:0] gate;
    logic [3:0] gate_oe;
    logic drv_en;
    logic [7:0] ramp_kohm;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } vss_regs_s;

  function automatic logic [REF_W-1:0] vss_units(input logic [CODE_W-1:0] code);
    vss_units = REF_W'(REF_W'(code) * CODE_LSB_UNITS);
  endfunction : vss_units
endpackage : vss_pkg

// File: hdl/vss_top.sv
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Function
// [R1] mask OV/UV during change, 16 steps after
// [R2] sample code rising, confirm falling edge
// [R3] step one LSB every two step clocks
// [R4] stepping clock runs at 1 MHz
// [R5] overcurrent during change latches disabled
// [R6] soft-start needs supplies ok and enable
// [R7] power good only after soft-start ends
// [R8] initial wait of at least 2 ms
// [R9] ramp to boot level, hold 200 us
// [R10] ramp boot to code level, same slope
// [R11] ramp time scales with resistor value
// [R12] undervoltage enabled from 0.5 V reference
// [R13] overvoltage fixed 1.24 V, then code-based
// [R14] code below boot ramps downward
// [R15] off code at hold end latches fault
// [R16] no code pulls before boot hold
// [R17] gates floating, driver enable low initially
// [R18] after first pulse gates switch, enable high
// [R19] overvoltage may still drive low sides
// [R20] two to four phases from gate straps
// [R21] trim each phase against phase average
// [R22] board straps unused gate outputs to ground
// [R23] overvoltage latches gates low, fault high
// [R24] stepping clock divided from system clock
module vss_top
  import vss_pkg::*;
#(
  parameter int INIT_DELAY_CYCLES = INIT_DELAY_CYC,
  parameter int BOOT_HOLD_CYCLES = BOOT_HOLD_CYC
) (
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  input wire logic I_SUPPLY_OK,
  input wire logic I_ENABLE,
  input wire logic [CODE_W-1:0] I_VCODE,
  input wire logic I_OV_TRIP,
  input wire logic I_UV_TRIP,
  input wire logic I_OC_TRIP,
  input wire logic [3:0] I_LOOP_PWM,
  input wire logic [3:0] I_GATE_I,
  input wire vss_cur_t I_PHASE_CUR,
  output logic [3:0] O_GATE_O,
  output logic [3:0] O_GATE_OE,
  output logic O_DRIVER_EN,
  output logic O_POWER_GOOD,
  output logic O_FAULT,
  output logic [REF_W-1:0] O_REF,
  output logic [REF_W-1:0] O_OV_LIMIT,
  output logic O_OV_EN,
  output logic O_UV_EN,
  output logic O_VCODE_PULL_EN,
  output vss_trim_t O_TRIM,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [7:0] I_AWADDR,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [7:0] I_ARADDR,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP
);

  localparam vss_regs_s REGS_RST = '{
    state: ST_IDLE,
    ramp_kohm: RAMP_KOHM_RST,
    phase_mask: 4'hF,
    default: '0
  };

  vss_regs_s r_q;
  vss_regs_s r_d;

  logic step_rise;
  logic step_fall;
  logic loop_on;
  logic mask;
  logic ramp_tick;
  logic [ACC_W-1:0] ramp_thr;
  logic [ACC_W-1:0] acc_sum;
  logic [REF_W-1:0] tgt;
  logic do_step;
  logic uv_en;
  logic ov_en;
  logic [13:0] cur_sum;
  logic [25:0] div3;
  logic [2:0] n_phase;
  logic [31:0] rd_word;
  logic rd_hit;

  always_comb begin
    r_d = r_q;
    // stepping clock from an integer divider, 40 system clocks per period
    step_rise = (r_q.step_div == '0); // [R24]
    step_fall = (r_q.step_div == STEP_HALF); // [R24]
    r_d.step_div = (r_q.step_div == STEP_LAST) ? '0 : r_q.step_div + 6'h01; // [R4]
    loop_on = (r_q.state == ST_RAMP_BOOT) || (r_q.state == ST_HOLD) ||
              (r_q.state == ST_RAMP_FINAL) || (r_q.state == ST_RUN);
    mask = r_q.dynamic_code_change_go || r_q.dynamic_code_change_act || (r_q.holdoff != '0); // [R1]
    // slope: one 0.25 mV unit whenever the accumulator passes kohm * 18.52 us
    ramp_thr = ACC_W'(r_q.ramp_kohm * SS_NS_PER_KOHM); // [R11]
    acc_sum = r_q.ss_acc + SS_ACC_INC;
    ramp_tick = (acc_sum >= ramp_thr); // [R11]
    tgt = r_q.dynamic_code_change_go ? vss_units(r_q.code) : r_q.target;
    do_step = step_rise && (r_q.dynamic_code_change_go || (r_q.dynamic_code_change_act && r_q.step_par));
    uv_en = loop_on && r_q.uv_arm && !mask; // [R12]
    ov_en = loop_on && !mask; // [R13]

    unique case (r_q.state)
      ST_RAMP_BOOT, ST_RAMP_FINAL: begin
        if (ramp_tick) begin
          // low resistor settings cap at one unit per clock
          r_d.ss_acc = (ramp_thr > SS_ACC_INC) ? acc_sum - ramp_thr : '0;
        end else begin
          r_d.ss_acc = acc_sum;
        end
      end
      default: r_d.ss_acc = '0;
    endcase

    if (!(I_SUPPLY_OK && I_ENABLE)) begin
      // reset, disable or supply loss are the only ways out of a latched fault
      r_d.state = ST_IDLE; // [R6]
      r_d.ref_lvl = '0;
      r_d.target = '0;
      r_d.tmr = '0;
      r_d.uv_arm = 1'b0;
      r_d.first_pulse = 1'b0;
      r_d.dynamic_code_change_go = 1'b0;
      r_d.dynamic_code_change_act = 1'b0;
      r_d.cand_pend = 1'b0;
      r_d.holdoff = '0;
      r_d.f_ov = 1'b0;
      r_d.f_oc = 1'b0;
      r_d.f_uv = 1'b0;
      r_d.f_off = 1'b0;
      // gates float while idle, so grounded straps read low
      if (!I_GATE_I[3]) begin
        r_d.phase_mask = I_GATE_I[1] ? 4'h7 : 4'h5; // [R20]
      end else begin
        r_d.phase_mask = 4'hF; // [R20]
      end
    end else begin
      unique case (r_q.state)
        ST_IDLE: begin
          r_d.state = ST_DELAY; // [R6]
          r_d.tmr = '0;
        end
        ST_DELAY: begin
          r_d.tmr = r_q.tmr + 1'b1;
          if (r_q.tmr == TMR_W'(INIT_DELAY_CYCLES - 1)) begin
            r_d.state = ST_RAMP_BOOT; // [R8]
          end
        end
        ST_RAMP_BOOT: begin
          if (r_q.ref_lvl == BOOT_UNITS) begin
            r_d.state = ST_HOLD; // [R9]
            r_d.target = BOOT_UNITS;
            r_d.tmr = '0;
          end else if (ramp_tick) begin
            r_d.ref_lvl = r_q.ref_lvl + 1'b1; // [R9]
          end
        end
        ST_HOLD: begin
          r_d.tmr = r_q.tmr + 1'b1;
          if (r_q.tmr == TMR_W'(BOOT_HOLD_CYCLES - 1)) begin
            if (I_VCODE == OFF_CODE_LO || I_VCODE == OFF_CODE_HI) begin
              r_d.f_off = 1'b1; // [R15]
              r_d.state = ST_FAULT; // [R15]
            end else begin
              r_d.code = I_VCODE;
              r_d.target = vss_units(I_VCODE);
              r_d.state = ST_RAMP_FINAL; // [R10]
            end
          end
        end
        ST_RAMP_FINAL: begin
          if (r_q.ref_lvl == r_q.target) begin
            r_d.state = ST_RUN; // [R7]
          end else if (ramp_tick) begin
            if (r_q.ref_lvl < r_q.target) begin
              r_d.ref_lvl = r_q.ref_lvl + 1'b1; // [R10]
            end else begin
              r_d.ref_lvl = r_q.ref_lvl - 1'b1; // [R14]
            end
          end
        end
        ST_RUN: begin
          if (step_rise) begin
            r_d.cand = I_VCODE; // [R2]
            r_d.cand_pend = (I_VCODE != r_q.code); // [R2]
          end
          if (step_fall && r_q.cand_pend) begin
            r_d.cand_pend = 1'b0;
            if (I_VCODE == r_q.cand) begin
              r_d.code = r_q.cand; // [R2]
              r_d.dynamic_code_change_go = 1'b1;
            end
          end
          if (step_rise && r_q.dynamic_code_change_go) begin
            r_d.dynamic_code_change_go = 1'b0;
            r_d.dynamic_code_change_act = 1'b1; // [R3]
            r_d.target = tgt;
          end
          if (step_rise && r_q.dynamic_code_change_act && !r_q.step_par) begin
            r_d.step_par = 1'b1; // [R3]
          end
          if (do_step) begin
            r_d.step_par = 1'b0;
            if (r_q.ref_lvl == tgt) begin
              r_d.dynamic_code_change_act = 1'b0;
              r_d.holdoff = MASK_HOLDOFF_STEPS; // [R1]
            end else if (r_q.ref_lvl < tgt) begin
              r_d.ref_lvl = (tgt - r_q.ref_lvl <= CODE_LSB_UNITS) ? tgt : r_q.ref_lvl + CODE_LSB_UNITS; // [R3]
            end else begin
              r_d.ref_lvl = (r_q.ref_lvl - tgt <= CODE_LSB_UNITS) ? tgt : r_q.ref_lvl - CODE_LSB_UNITS; // [R3]
            end
          end else if (step_rise && !r_q.dynamic_code_change_act && !r_q.dynamic_code_change_go && r_q.holdoff != '0) begin
            r_d.holdoff = r_q.holdoff - 1'b1; // [R1]
          end
        end
        ST_FAULT: r_d.state = ST_FAULT;
      endcase

      if (loop_on) begin
        if (r_q.ref_lvl >= UV_ARM_UNITS) begin
          r_d.uv_arm = 1'b1; // [R12]
        end
        if (|(I_LOOP_PWM & r_q.phase_mask)) begin
          r_d.first_pulse = 1'b1; // [R18]
        end
        // overcurrent is never masked, also not during a code change
        if (I_OC_TRIP) begin
          r_d.f_oc = 1'b1; // [R5]
          r_d.state = ST_FAULT;
        end
        if (I_UV_TRIP && uv_en) begin
          r_d.f_uv = 1'b1; // [R12]
          r_d.state = ST_FAULT;
        end
        if (I_OV_TRIP && ov_en) begin
          r_d.f_ov = 1'b1; // [R23]
          r_d.state = ST_FAULT;
        end
      end
    end

    // gate drive from next-state flags, so outputs line up with the latch
    if (r_d.f_ov) begin
      r_d.gate = '0; // [R23]
      r_d.gate_oe = r_q.phase_mask; // [R19]
      r_d.drv_en = 1'b1; // [R23]
    end else if (r_d.state == ST_FAULT || r_d.state == ST_IDLE || !r_d.first_pulse) begin
      r_d.gate = '0;
      r_d.gate_oe = '0; // [R17]
      r_d.drv_en = 1'b0; // [R17]
    end else begin
      r_d.gate = I_LOOP_PWM & r_q.phase_mask; // [R18]
      r_d.gate_oe = r_q.phase_mask; // [R18]
      r_d.drv_en = 1'b1; // [R18]
    end

    // current sharing over the working phases only
    cur_sum = '0;
    for (int p = 0; p < 4; p++) begin
      if (r_q.phase_mask[p]) begin
        cur_sum = cur_sum + 14'(I_PHASE_CUR[p]); // [R21]
      end
    end
    n_phase = 3'(r_q.phase_mask[0]) + 3'(r_q.phase_mask[1]) + 3'(r_q.phase_mask[2]) + 3'(r_q.phase_mask[3]);
    div3 = 26'(cur_sum * DIV3_MUL);
    unique case (n_phase)
      3'h2: r_d.avg = CUR_W'(cur_sum >> 1); // [R21]
      3'h3: r_d.avg = CUR_W'(div3 >> 12); // [R21]
      default: r_d.avg = CUR_W'(cur_sum >> 2); // [R21]
    endcase
    for (int p = 0; p < 4; p++) begin
      r_d.trim[p] = r_q.phase_mask[p] ? ((CUR_W + 1)'(I_PHASE_CUR[p]) - (CUR_W + 1)'(r_q.avg)) : '0; // [R21]
    end

    // bus slave: address and data taken in either order
    if (I_AWVALID && !r_q.aw_got && !r_q.bvalid) begin
      r_d.aw_got = 1'b1;
      r_d.aw_addr = I_AWADDR;
    end
    if (I_WVALID && !r_q.w_got && !r_q.bvalid) begin
      r_d.w_got = 1'b1;
      r_d.wdata = I_WDATA;
      r_d.wstrb = I_WSTRB;
    end
    if (r_q.aw_got && r_q.w_got) begin
      r_d.aw_got = 1'b0;
      r_d.w_got = 1'b0;
      r_d.bvalid = 1'b1;
      r_d.bresp = RESP_OKAY;
      unique case (r_q.aw_addr)
        ADDR_RAMP: begin
          if (r_q.wstrb[0]) begin
            r_d.ramp_kohm = r_q.wdata[7:0]; // [R11]
          end
        end
        ADDR_STATUS, ADDR_REF, ADDR_CURRENT: r_d.bresp = RESP_OKAY;
        default: r_d.bresp = RESP_DECERR;
      endcase
    end
    if (r_q.bvalid && I_BREADY) begin
      r_d.bvalid = 1'b0;
    end

    rd_hit = 1'b1;
    unique case (I_ARADDR)
      ADDR_STATUS: begin
        rd_word = '0;
        rd_word[3:0] = 4'(r_q.state);
        rd_word[STAT_PGOOD_BIT] = (r_q.state == ST_RUN);
        rd_word[STAT_FOV_BIT] = r_q.f_ov;
        rd_word[STAT_FOC_BIT] = r_q.f_oc;
        rd_word[STAT_FUV_BIT] = r_q.f_uv;
        rd_word[STAT_FOFF_BIT] = r_q.f_off;
        rd_word[STAT_DYNAMIC_CODE_CHANGE_BIT] = r_q.dynamic_code_change_act;
        rd_word[STAT_MASK_BIT] = mask;
        rd_word[STAT_PHASE_LSB +: 4] = r_q.phase_mask;
      end
      ADDR_RAMP: rd_word = {24'h00_0000, r_q.ramp_kohm};
      ADDR_REF: begin
        rd_word = '0;
        rd_word[REF_W-1:0] = r_q.ref_lvl;
        rd_word[REF_TARGET_LSB +: REF_W] = r_q.target;
      end
      ADDR_CURRENT: rd_word = {20'h0_0000, r_q.avg};
      default: begin
        rd_word = '0;
        rd_hit = 1'b0;
      end
    endcase
    if (I_ARVALID && !r_q.rvalid) begin
      r_d.rvalid = 1'b1;
      r_d.rdata = rd_word;
      r_d.rresp = rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (r_q.rvalid && I_RREADY) begin
      r_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      r_q <= REGS_RST;
    end else begin
      r_q <= r_d;
    end
  end

  assign O_GATE_O = r_q.gate;
  assign O_GATE_OE = r_q.gate_oe;
  assign O_DRIVER_EN = r_q.drv_en;
  assign O_POWER_GOOD = (r_q.state == ST_RUN); // [R7]
  assign O_FAULT = r_q.f_ov; // [R23]
  assign O_REF = r_q.ref_lvl;
  assign O_OV_LIMIT = (r_q.state == ST_RAMP_BOOT) ? OV_FIXED_UNITS : r_q.target + OV_MARGIN_UNITS; // [R13]
  assign O_OV_EN = ov_en; // [R13]
  assign O_UV_EN = uv_en; // [R12]
  // code lines stay unloaded until the boot hold begins
  assign O_VCODE_PULL_EN = (r_q.state == ST_HOLD) || (r_q.state == ST_RAMP_FINAL) || (r_q.state == ST_RUN); // [R16]
  assign O_TRIM = r_q.trim;
  assign O_AWREADY = !r_q.aw_got && !r_q.bvalid;
  assign O_WREADY = !r_q.w_got && !r_q.bvalid;
  assign O_BVALID = r_q.bvalid;
  assign O_BRESP = r_q.bresp;
  assign O_ARREADY = !r_q.rvalid;
  assign O_RVALID = r_q.rvalid;
  assign O_RDATA = r_q.rdata;
  assign O_RRESP = r_q.rresp;

endmodule : vss_top

// File: tb/vid_softstart_sequencer_bench.sv
`timescale 1ns/1ps
module vid_softstart_sequencer_bench;
  import vss_pkg::*;
  localparam int INIT_CYC = 20;
  localparam int HOLD_CYC = 20;
  logic clk;
  logic rst_n = 1'b0;
  logic en = 1'b0;
  logic ovt = 1'b0;
  logic uvt = 1'b0;
  logic sok = 1'b1;
  logic oct = 1'b0;
  logic [3:0] pwm = 4'h0;
  logic [1:0] ph = 2'h0;
  logic [7:0] code = 8'hC8;
  vss_cur_t cur = '0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0] ws = 4'h0;
  logic [3:0] go, goe, gi;
  logic drv, pg, fault_out, ove, uve, pull, awr, wr, bv, arr, rv;
  logic [REF_W-1:0] rf;
  logic [7:0] vc;
  vss_trim_t trim;
  logic [1:0] br, rr;
  logic [31:0] rd;
  int fails = 0;
  int n_compared = 0;
  int td, tr, th;

  vss_top #(.INIT_DELAY_CYCLES(INIT_CYC), .BOOT_HOLD_CYCLES(HOLD_CYC)) u_dut (
    .I_CLOCK(clk), .I_RESET_N(rst_n), .I_SUPPLY_OK(sok), .I_ENABLE(en), .I_VCODE(vc),
    .I_OV_TRIP(ovt), .I_UV_TRIP(uvt), .I_OC_TRIP(oct), .I_LOOP_PWM(pwm), .I_GATE_I(gi),
    .I_PHASE_CUR(cur), .O_GATE_O(go), .O_GATE_OE(goe), .O_DRIVER_EN(drv), .O_POWER_GOOD(pg),
    .O_FAULT(fault_out), .O_REF(rf), .O_OV_LIMIT(), .O_OV_EN(ove), .O_UV_EN(uve), .O_VCODE_PULL_EN(pull),
    .O_TRIM(trim), .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wr),
    .I_WDATA(wd), .I_WSTRB(ws), .O_BVALID(bv), .I_BREADY(bry), .O_BRESP(br), .I_ARVALID(arv),
    .O_ARREADY(arr), .I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rry), .O_RDATA(rd), .O_RRESP(rr)
  );
  vss_partner u_partner (.i_gate_o(go), .i_gate_oe(goe), .i_phases(ph), .i_code(code), .o_gate_i(gi), .o_vcode(vc));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    ws <= 4'hF;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (!(bry && bv));
    chk(br, RESP_OKAY, "write response");
    bry <= 1'b0;
    @(posedge clk);
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end while (!(rry && rv));
    d = rd;
    r = rr;
    rry <= 1'b0;
    @(posedge clk);
  endtask : axr

  task automatic wref(input logic [REF_W-1:0] t, output int n);
    n = 0;
    while (rf !== t && n < 40000) begin
      @(posedge clk);
      n++;
    end
  endtask : wref

  // straps are only read while disabled or a supply is low, so the phase count changes here
  task automatic off(input logic [1:0] p);
    en <= 1'b0;
    ph <= p;
    repeat (4) @(posedge clk);
  endtask : off

  task automatic boot(input logic [7:0] c);
    int bad;
    bad = 0;
    code <= c;
    pwm <= 4'h0;
    en <= 1'b1;
    td = 0;
    while (rf === '0 && td < 1000) begin
      @(posedge clk);
      td++;
    end
    chk(td >= INIT_CYC && td < 1000, 1, "initial delay");
    tr = 0;
    while (rf !== BOOT_UNITS && tr < 30000) begin
      @(posedge clk);
      tr++;
      if (pull !== 1'b0 || pg !== 1'b0 || drv !== 1'b0) bad++;
    end
    chk(bad, 0, "outputs during ramp");
    th = 0;
    while (rf === BOOT_UNITS && th < 200) begin
      @(posedge clk);
      th++;
    end
  endtask : boot

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int n;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({pg, drv, goe}, 6'h00, "reset outputs");
    axr(ADDR_RAMP, d, r);
    chk(d[7:0], RAMP_KOHM_RST, "ramp reset value");
    axr(8'h10, d, r);
    chk(r, RESP_DECERR, "unmapped read");
    axw(ADDR_STATUS, 32'hFFFF_FFFF);
    axr(ADDR_STATUS, d, r);
    chk(d[3:0], 4'h0, "status idle");
    off(2'h0);
    // enable alone must not start anything while a supply is low
    sok <= 1'b0;
    en <= 1'b1;
    repeat (40) @(posedge clk);
    chk({rf, pg}, 14'h0000, "no start on supply low");
    sok <= 1'b1;
    boot(8'hC8);
    chk(tr >= 19600 && tr <= 20400, 1, "boot ramp time");
    chk(th >= HOLD_CYC, 1, "boot hold");
    wref(13'h1388, n);
    chk(n >= 3000 && n <= 3260, 1, "final ramp slope");
    repeat (3) @(posedge clk);
    chk({pg, drv, goe, pull}, 7'h41, "run before first pulse");
    pwm <= 4'h5;
    repeat (3) @(posedge clk);
    chk({drv, goe, go}, 9'h1F5, "after first pulse");
    // a glitch shorter than half a stepping clock can never be confirmed
    code <= 8'hC9;
    repeat (8) @(posedge clk);
    code <= 8'hC8;
    repeat (400) @(posedge clk);
    chk({rf, ove}, {13'h1388, 1'b1}, "glitch ignored");
    code <= 8'hCB;
    wref(13'h13D3, n);
    chk(n >= 190 && n <= 250, 1, "step pace");
    chk({ove, uve}, 2'b00, "masked after change");
    // trips inside the masked window must not latch
    ovt <= 1'b1;
    uvt <= 1'b1;
    @(posedge clk);
    ovt <= 1'b0;
    uvt <= 1'b0;
    repeat (1100) @(posedge clk);
    chk({ove, uve, pg, fault_out}, 4'hE, "unmasked later");
    code <= 8'hC8;
    wref(13'h1388, n);
    chk(rf, 13'h1388, "step down");
    repeat (1100) @(posedge clk);
    ovt <= 1'b1;
    repeat (3) @(posedge clk);
    ovt <= 1'b0;
    repeat (3) @(posedge clk);
    chk({fault_out, drv, go}, 6'h30, "overvoltage latch");
    off(2'h1);
    chk(fault_out, 1'b0, "enable cycle clears");
    cur <= {12'h3E7, 12'h12C, 12'h0C8, 12'h064};
    axw(ADDR_RAMP, 32'h0000_0006);
    boot(8'hFF);
    chk({rf, pg}, {BOOT_UNITS, 1'b0}, "off code stops at boot");
    axr(ADDR_STATUS, d, r);
    chk(d[STAT_FOFF_BIT], 1'b1, "off code latched");
    chk(d[STAT_PHASE_LSB +: 4], 4'h7, "three phases");
    axr(ADDR_CURRENT, d, r);
    chk(d[11:0], 12'h0C8, "three phase average");
    off(2'h2);
    cur <= {12'h3E7, 12'h12C, 12'h3E7, 12'h064};
    boot(8'h40);
    wref(13'h0640, n);
    repeat (3) @(posedge clk);
    chk(pg, 1'b1, "ramp down below boot");
    pwm <= 4'h5;
    axr(ADDR_STATUS, d, r);
    chk(d[15:12], 4'h5, "two phases");
    axr(ADDR_CURRENT, d, r);
    chk(d[11:0], 12'h0C8, "average current");
    chk({trim[2], trim[0]}, {13'h0064, 13'h1F9C}, "trim working");
    chk({trim[3], trim[1]}, 26'h0, "trim idle phases");
    chk({drv, goe, go}, 9'h155, "two phase gates");
    code <= 8'h42;
    wref(13'h0659, n);
    oct <= 1'b1;
    repeat (4) @(posedge clk);
    oct <= 1'b0;
    repeat (4) @(posedge clk);
    chk({pg, drv, goe}, 6'h00, "overcurrent latch");
    summarize();
  end

  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    summarize();
  end
endmodule : vid_softstart_sequencer_bench

// File: tb/vss_partner.sv
`timescale 1ns/1ps
module vss_partner
  import vss_pkg::*;
(
  input wire logic [3:0] i_gate_o,
  input wire logic [3:0] i_gate_oe,
  input wire logic [1:0] i_phases,
  input wire logic [CODE_W-1:0] i_code,
  output logic [3:0] o_gate_i,
  output logic [CODE_W-1:0] o_vcode
);
  logic [3:0] wired;
  // phases: 0 four, 1 three, 2 two; a driver input idles high when not driven
  always_comb begin
    wired = 4'hF;
    if (i_phases != 2'h0) wired[3] = 1'b0;
    if (i_phases == 2'h2) wired[1] = 1'b0;
    o_gate_i = wired & ((i_gate_oe & i_gate_o) | ~i_gate_oe);
  end
  // the processor drives its code lines hard, so missing pulls never float them
  assign o_vcode = i_code;
endmodule : vss_partner

// File: tb/vss_sva.sv
`timescale 1ns/1ps
module vss_sva
  import vss_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  input wire logic I_OC_TRIP,
  input wire logic [3:0] O_GATE_O,
  input wire logic [3:0] O_GATE_OE,
  input wire logic O_DRIVER_EN,
  input wire logic O_POWER_GOOD,
  input wire logic O_FAULT,
  input wire logic [REF_W-1:0] O_REF,
  input wire logic [REF_W-1:0] O_OV_LIMIT,
  input wire logic O_OV_EN,
  input wire logic O_UV_EN
);
  // cycles since the last step in run; saturates so long idle spans never wrap
  logic [9:0] gap_q;
  logic [9:0] gap_d;
  logic [REF_W-1:0] ref_q;
  logic pg_q;
  logic step;
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESET_N);
  assign step = O_POWER_GOOD && pg_q && (O_REF != ref_q);
  always_comb begin
    gap_d = (gap_q == 10'h3FF) ? gap_q : gap_q + 10'h001;
    if (!O_POWER_GOOD) gap_d = 10'h3FF;
    else if (step) gap_d = 10'h000;
  end
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      gap_q <= 10'h3FF;
      ref_q <= '0;
      pg_q <= 1'b0;
    end else begin
      gap_q <= gap_d;
      ref_q <= O_REF;
      pg_q <= O_POWER_GOOD;
    end
  end
  sequence s_halted;
    !O_DRIVER_EN && O_GATE_OE == 4'h0;
  endsequence
  gate_hiz_a: assert property (!O_DRIVER_EN |-> O_GATE_OE == 4'h0)
    else $error("gates driven while driver enable low");
  ov_hold_a: assert property (O_FAULT && $past(O_FAULT) |-> O_GATE_O == 4'h0 && O_DRIVER_EN)
    else $error("overvoltage latch lost low sides");
  ov_fixed_a: assert property (!O_POWER_GOOD && O_REF > ref_q && O_REF < BOOT_UNITS |-> O_OV_LIMIT == OV_FIXED_UNITS)
    else $error("overvoltage limit not fixed on boot ramp");
  ov_active_a: assert property (!O_POWER_GOOD && O_REF > ref_q |-> O_OV_EN)
    else $error("overvoltage off during soft start");
  uv_early_a: assert property (!O_POWER_GOOD && O_REF > ref_q && O_REF < UV_ARM_UNITS |-> !O_UV_EN)
    else $error("undervoltage armed too early");
  pg_limit_a: assert property ($rose(O_POWER_GOOD) |-> O_OV_LIMIT == O_REF + OV_MARGIN_UNITS)
    else $error("power good before code limit in force");
  step_size_a: assert property (step |-> O_REF == ref_q + CODE_LSB_UNITS || ref_q == O_REF + CODE_LSB_UNITS)
    else $error("reference step not one code");
  step_gap_a: assert property (step && gap_q < 10'h0C8 |-> gap_q == 10'h04F)
    else $error("reference steps not two stepping clocks apart");
  dynamic_code_change_mask_a: assert property (O_POWER_GOOD && gap_q < 10'h258 |-> !O_OV_EN && !O_UV_EN)
    else $error("detection live during code change or holdoff");
  // holdoff ends 18 stepping clocks after the last step, so the window opens past 720 cycles
  mask_release_a: assert property (O_POWER_GOOD && !O_FAULT && gap_q > 10'h2D0 && gap_q < 10'h3E8 |-> O_OV_EN && O_UV_EN)
    else $error("detection not restored after holdoff");
  oc_stop_a: assert property (O_POWER_GOOD && I_OC_TRIP |-> ##[1:3] s_halted [*4])
    else $error("overcurrent did not latch off");
endmodule : vss_sva
bind vss_top vss_sva u_sva (
  .I_CLOCK(I_CLOCK), .I_RESET_N(I_RESET_N), .I_OC_TRIP(I_OC_TRIP), .O_GATE_O(O_GATE_O),
  .O_GATE_OE(O_GATE_OE), .O_DRIVER_EN(O_DRIVER_EN), .O_POWER_GOOD(O_POWER_GOOD), .O_FAULT(O_FAULT),
  .O_REF(O_REF), .O_OV_LIMIT(O_OV_LIMIT), .O_OV_EN(O_OV_EN), .O_UV_EN(O_UV_EN)
);
